// File: design/asrc_params.svh
// timing and field constants for the async sram host controller, with the rule summary
// Summary of operation
// - controller changes address only while strobe high or memory deselected.
// - controller holds both selects active across the whole data setup window.
// - controller never drives data while memory may still drive it.
// - strobe write with gate low stretches pulse to float delay plus setup.
// - controller presents valid address no later than select activation for reads.
`ifndef ASRC_PARAMS_SVH
`define ASRC_PARAMS_SVH
`define ASRC_CLK_PERIOD_NS 100
`define ASRC_T_ACCESS_NS 15
`define ASRC_T_GATE_ACCESS_NS 8
`define ASRC_T_WRITE_PULSE_NS 12
`define ASRC_T_WHZ_NS 5
`define ASRC_T_DATA_SETUP_NS 8
// least times round up to whole cycles, never below one
`define ASRC_CYC_UP(t) (((t) + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_RD_CYCLES `ASRC_CYC_UP(`ASRC_T_ACCESS_NS)
`define ASRC_WR_CYCLES `ASRC_CYC_UP(`ASRC_T_WHZ_NS + `ASRC_T_DATA_SETUP_NS)
`define ASRC_WP_CYCLES `ASRC_CYC_UP(`ASRC_T_WRITE_PULSE_NS)
`define ASRC_ADDR_W 17
`define ASRC_DATA_W 8
// stages of the read data synchroniser, added to the read wait
`define ASRC_SYNC_STAGES 2
`define ASRC_CNT_ZERO 4'h0
`endif

// File: design/asrc_pkg.sv
// types shared by the async sram host controller
package asrc_pkg;
   typedef enum logic [2:0] {
      ASRC_IDLE = 3'b000,
      ASRC_RSET = 3'b001,
      ASRC_RWAIT = 3'b010,
      ASRC_WSET = 3'b011,
      ASRC_WPULSE = 3'b100,
      ASRC_WEND = 3'b101
   } asrc_state_t;
endpackage

// File: design/asrc_timer_if.sv
// carrier between the sequencer and its wait timer
`timescale 1ns/1ns
interface asrc_timer_if;
   logic load;
   logic [3:0] count;
   logic done;
   modport seq (output load, output count, input done);
   modport tmr (input load, input count, output done);
endinterface

// File: design/asrc_timer.sv
// down counter that times strobe and access intervals
`timescale 1ns/1ns
`include "asrc_params.svh"
module asrc_timer (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   asrc_timer_if.tmr t
);
   typedef struct packed {
      logic [3:0] cnt;
   } asrc_tmr_t;
   asrc_tmr_t s;
   asrc_tmr_t next_s;
   // load wins over counting so a new interval always starts fresh
   always_comb
   begin
      next_s = s;
      if (t.load)
         next_s.cnt = t.count;
      else if (s.cnt != `ASRC_CNT_ZERO)
         next_s.cnt = s.cnt - 4'h1;
   end
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         s <= '0;
      else
         s <= next_s;
   end
   assign t.done = (s.cnt == `ASRC_CNT_ZERO) && !t.load;
endmodule // asrc_timer

// File: design/asrc_ctrl.sv
// host controller that reads and writes an asynchronous 128k x 8 sram over its pins
`timescale 1ns/1ns
`include "asrc_params.svh"
module asrc_ctrl #(
   parameter int ADDR_W = `ASRC_ADDR_W,
   parameter int DATA_W = `ASRC_DATA_W
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic req_valid_i,
   input wire logic req_write_i,
   input wire logic [ADDR_W-1:0] req_addr_i,
   input wire logic [DATA_W-1:0] req_wdata_i,
   output logic req_ready_o,
   output logic rsp_valid_o,
   output logic [DATA_W-1:0] rsp_rdata_o,
   output logic [ADDR_W-1:0] mem_addr_o,
   output logic select_low_active_n_o,
   output logic select_high_active_o,
   output logic gate_n_o,
   output logic write_n_o,
   output logic [DATA_W-1:0] mem_data_o,
   output logic mem_data_oe_o,
   input wire logic [DATA_W-1:0] mem_data_i
);
   typedef struct packed {
      asrc_pkg::asrc_state_t st;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [DATA_W-1:0] rdata;
      logic rsp;
      logic sel;
      logic gate;
      logic wr;
      logic oe;
      logic [DATA_W-1:0] d_meta;
      logic [DATA_W-1:0] d_sync;
   } asrc_ctrl_t;
   asrc_ctrl_t s;
   asrc_ctrl_t next_s;
   asrc_timer_if tif ();
   asrc_timer u_timer (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .t(tif.tmr)
   );
   // sequencer: address settles before selects, strobes inside selects
   always_comb
   begin
      next_s = s;
      next_s.rsp = 1'b0;
      // read data from the pins goes through two flops before use
      next_s.d_meta = mem_data_i;
      next_s.d_sync = s.d_meta;
      tif.load = 1'b0;
      tif.count = `ASRC_CNT_ZERO;
      unique case (s.st)
         asrc_pkg::ASRC_IDLE:
         begin
            if (req_valid_i)
            begin
               next_s.addr = req_addr_i;
               next_s.wdata = req_wdata_i;
               next_s.st = req_write_i ? asrc_pkg::ASRC_WSET : asrc_pkg::ASRC_RSET;
            end
         end
         asrc_pkg::ASRC_RSET:
         begin
            // selects and gate rise together after the address is stable
            next_s.sel = 1'b1;
            next_s.gate = 1'b1;
            tif.load = 1'b1;
            // two flop sync on data adds to the access wait
            tif.count = 4'(`ASRC_RD_CYCLES + `ASRC_SYNC_STAGES);
            next_s.st = asrc_pkg::ASRC_RWAIT;
         end
         asrc_pkg::ASRC_RWAIT:
         begin
            if (tif.done)
            begin
               next_s.rdata = s.d_sync;
               next_s.rsp = 1'b1;
               next_s.sel = 1'b0;
               next_s.gate = 1'b0;
               next_s.st = asrc_pkg::ASRC_IDLE;
            end
         end
         asrc_pkg::ASRC_WSET:
         begin
            // gate stays high during writes so the memory never drives
            next_s.sel = 1'b1;
            next_s.wr = 1'b1;
            next_s.oe = 1'b1;
            tif.load = 1'b1;
            // pulse covers float plus setup and the plain minimum
            tif.count = 4'((`ASRC_WR_CYCLES > `ASRC_WP_CYCLES) ? `ASRC_WR_CYCLES : `ASRC_WP_CYCLES);
            next_s.st = asrc_pkg::ASRC_WPULSE;
         end
         asrc_pkg::ASRC_WPULSE:
         begin
            // selects held for the whole pulse; strobe ends the write
            if (tif.done)
            begin
               next_s.wr = 1'b0;
               next_s.st = asrc_pkg::ASRC_WEND;
            end
         end
         asrc_pkg::ASRC_WEND:
         begin
            // data held one cycle past strobe rise, then release all
            next_s.sel = 1'b0;
            next_s.oe = 1'b0;
            next_s.rsp = 1'b1;
            next_s.st = asrc_pkg::ASRC_IDLE;
         end
         default:
         begin
            next_s.st = asrc_pkg::ASRC_IDLE;
            next_s.sel = 1'b0;
            next_s.gate = 1'b0;
            next_s.wr = 1'b0;
            next_s.oe = 1'b0;
         end
      endcase
   end
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         s <= '0;
      else
         s <= next_s;
   end
   // pins: address only moves in idle, where selects are inactive
   assign mem_addr_o = s.addr;
   assign select_low_active_n_o = !s.sel;
   assign select_high_active_o = s.sel;
   assign gate_n_o = !s.gate;
   assign write_n_o = !s.wr;
   assign mem_data_o = s.wdata;
   assign mem_data_oe_o = s.oe;
   assign req_ready_o = (s.st == asrc_pkg::ASRC_IDLE);
   assign rsp_valid_o = s.rsp;
   assign rsp_rdata_o = s.rdata;
endmodule // asrc_ctrl

// File: test/asrc_sram_model.sv
// behavioural asynchronous 128k x 8 memory that faces the host controller
`timescale 1ns/1ns
module asrc_sram_model #(
   parameter int DLY = 0
) (
   input wire logic [16:0] addr_i,
   input wire logic sel_n_i,
   input wire logic sel_i,
   input wire logic gate_n_i,
   input wire logic we_n_i,
   input wire logic [7:0] host_d_i,
   input wire logic host_oe_i,
   output logic [7:0] bus_o
);
   logic [7:0] mem [0:131071];
   logic [7:0] last = 8'h00;
   logic drive;
   // no clock anywhere: a write lands while both selects and the strobe are active
   always @* if (!sel_n_i && sel_i && !we_n_i) mem[addr_i] = host_d_i;
   // drive only in read state, so a strobe that falls first never sees the pins turn on
   assign drive = !sel_n_i && sel_i && we_n_i && !gate_n_i;
   // no pull on the bus, so a released bus shows the inverse of its last level
   always @* if (drive) last = mem[addr_i]; else if (host_oe_i) last = host_d_i;
   assign #(DLY) bus_o = drive ? mem[addr_i] : (host_oe_i ? host_d_i : ~last);
endmodule // asrc_sram_model

// File: test/asrc_ctrl_asserts.sv
// pin timing checks for the async sram host controller
`timescale 1ns/1ns
module asrc_ctrl_asserts (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic req_valid_i,
   input wire logic req_write_i,
   input wire logic req_ready_o,
   input wire logic rsp_valid_o,
   input wire logic [16:0] mem_addr_o,
   input wire logic select_low_active_n_o,
   input wire logic select_high_active_o,
   input wire logic gate_n_o,
   input wire logic write_n_o,
   input wire logic mem_data_oe_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   wire sel = !select_low_active_n_o && select_high_active_o;
   wire tk = req_valid_i && req_ready_o;
   property p_addr; sel ##1 sel |-> $stable(mem_addr_o); endproperty
   a_addr: assert property (p_addr) else $error("address moved while selected");
   property p_setup; $fell(select_low_active_n_o) |-> $stable(mem_addr_o); endproperty
   a_setup: assert property (p_setup) else $error("address late for select");
   property p_wsel; !write_n_o || $rose(write_n_o) |-> sel && mem_data_oe_o; endproperty
   a_wsel: assert property (p_wsel) else $error("select or data dropped in write window");
   property p_cont; mem_data_oe_o |-> gate_n_o && $past(gate_n_o); endproperty
   a_cont: assert property (p_cont) else $error("bus driven against memory");
   property p_gate; !write_n_o |-> gate_n_o; endproperty
   a_gate: assert property (p_gate) else $error("gate low during strobe");
   // selects and gate stand from the second to the fifth sampled edge after the take
   property p_rd; tk && !req_write_i |-> ##2 (sel && !gate_n_o) [*4] ##1 (rsp_valid_o && !sel); endproperty
   a_rd: assert property (p_rd) else $error("read sequence wrong");
   property p_wr;
      tk && req_write_i |-> ##2 (sel && !write_n_o) [*2] ##1 (sel && write_n_o)
         ##1 (rsp_valid_o && !sel && !mem_data_oe_o);
   endproperty
   a_wr: assert property (p_wr) else $error("write sequence wrong");
   property p_b2b; rsp_valid_o |-> req_ready_o; endproperty
   a_b2b: assert property (p_b2b) else $error("not ready at completion");
   c_rd: cover property (tk && !req_write_i);
   c_wr: cover property (tk && req_write_i);
   c_b2b: cover property (rsp_valid_o && req_valid_i);
endmodule // asrc_ctrl_asserts

// File: test/asrc_ctrl_test.sv
// self-checking bench for the async sram host controller
`timescale 1ns/1ns
module asrc_ctrl_test;
   logic mclk_i = 0, sys_rst_i = 1, req_valid_i = 0, req_write_i = 0, rsp_valid_o, req_ready_o, oe, sn, sh, gn, wn;
   logic [16:0] req_addr_i = 17'h00000, ma;
   logic [7:0] req_wdata_i = 8'h00, rsp_rdata_o, md, bus, q;
   int error_cnt = 0, checks = 0, cyc = 0, lat, n;
   asrc_ctrl DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i), .req_write_i(req_write_i),
      .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
      .rsp_rdata_o(rsp_rdata_o), .mem_addr_o(ma), .select_low_active_n_o(sn), .select_high_active_o(sh),
      .gate_n_o(gn), .write_n_o(wn), .mem_data_o(md), .mem_data_oe_o(oe), .mem_data_i(bus));
   // slow grade partner: answers 60 ns after the gate, still inside one cycle
   asrc_sram_model #(.DLY(60)) u_mem (.addr_i(ma), .sel_n_i(sn), .sel_i(sh), .gate_n_i(gn), .we_n_i(wn),
      .host_d_i(md), .host_oe_i(oe), .bus_o(bus));
   initial forever #50 mclk_i = ~mclk_i;
   // a hang is cut short well past the sixty or so cycles the tests need
   always @(posedge mclk_i) if (++cyc == 2000) begin error_cnt++; print_verdict(); end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string m);
      checks++;
      if (seen !== exp) begin error_cnt++; $display("CHECK FAILED %0t %s", $time, m); end
   endtask
   // request held until taken, then response awaited under a bound
   task automatic xfer(input logic w, input logic [16:0] a, input logic [7:0] d);
      req_valid_i <= 1; req_write_i <= w; req_addr_i <= a; req_wdata_i <= d;
      do @(posedge mclk_i); while (req_ready_o !== 1'b1);
      req_valid_i <= 0;
      // lat counts up to the edge that launches the answer, which is seen one edge later
      lat = 0;
      @(posedge mclk_i);
      while (rsp_valid_o !== 1'b1 && lat < 20)
      begin
         lat++;
         @(posedge mclk_i);
      end
      q = rsp_rdata_o;
   endtask
   task automatic t_idle();
      chk({2'h0, sn, sh, gn, wn, oe, req_ready_o}, 8'h2d, "idle pins");
      $display("test idle done");
   endtask
   task automatic t_wr_rd();
      logic [16:0] a[3] = '{17'h00000, 17'h1ffff, 17'h0a5a5};
      logic [7:0] d[3] = '{8'h3c, 8'hc3, 8'h5a};
      for (int i = 0; i < 3; i++) begin xfer(1, a[i], d[i]); chk(8'(lat), 8'h04, "write latency"); end
      for (int i = 0; i < 3; i++)
      begin
         xfer(0, a[i], 8'h00);
         chk(8'(lat), 8'h05, "read latency");
         chk(q, d[i], "read data");
      end
      $display("test write read done");
   endtask
   task automatic t_b2b();
      n = 0;
      req_valid_i <= 1; req_write_i <= 0; req_addr_i <= 17'h1ffff;
      // second request moves to a new address once the first is taken
      for (int i = 0; i < 13; i++)
      begin
         @(posedge mclk_i);
         n += rsp_valid_o;
         if (i == 0) req_addr_i <= 17'h00000;
         if (i == 9) req_valid_i <= 0;
      end
      chk(8'(n), 8'h02, "back to back count");
      chk(rsp_rdata_o, 8'h3c, "back to back data");
      $display("test back to back done");
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge mclk_i);
      sys_rst_i <= 0;
      @(posedge mclk_i);
      t_idle();
      t_wr_rd();
      t_b2b();
      print_verdict();
   end
endmodule // asrc_ctrl_test
bind asrc_ctrl asrc_ctrl_asserts u_chk (.*);
